// ==== rtl/pnp_logical_device_config_regs.sv ====
// Logical-device configuration register bank with window decode.
`timescale 1ns/1ps
module pnp_logical_device_config_regs (
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        nrst_in,
	// Host configuration ports, already synchronous to clock_in
	input  wire logic        addr_port_wr_in,
	input  wire logic        data_port_wr_in,
	input  wire logic        data_port_rd_in,
	input  wire logic [7:0]  host_wdata_in,
	// Card state events from the card-level logic
	input  wire logic        isolation_won_in,
	input  wire logic        wait_for_key_in,
	// Host memory and I/O cycle qualifiers
	input  wire logic        mem_cycle_in,
	input  wire logic [23:0] mem_addr_in,
	input  wire logic        io_range_read_in,
	// Configuration read data
	output logic [7:0]       host_rdata_out,
	output logic             host_rdata_oe_n_out,
	// Decoded window and mode outputs
	output logic             device_active_out,
	output logic             internal_mem_hit_out,
	output logic             external_chip_select_out,
	output logic             internal_wide_out,
	output logic             chipsel_wide_out,
	output logic [7:0]       io_check_data_out,
	output logic             io_check_drive_out
);

	// Card state and index register
	pnp_ldev_pkg::card_state_t state_reg;
	logic [7:0]  index_reg;

	// Stored fields; reserved and read-only bits have no storage, so
	// a host write to them cannot disturb anything
	logic        device_active_flag_reg;
	logic        check_en_reg;
	logic        check_pattern_select_reg;
	logic [7:0]  internal_mem_base_high_reg;
	logic [3:0]  internal_mem_base_low_reg;
	logic        int_width_reg;
	logic        internal_memory_enable_reg;
	logic [7:0]  chipsel_base_high_reg;
	logic [7:0]  chipsel_base_low_reg;
	logic        cs_width_reg;

	// Derived values
	logic        in_config;
	logic        cfg_write;
	logic [7:0]  read_value;
	logic [15:0] internal_base;
	logic [15:0] internal_range_mask;
	logic [15:0] chipsel_window_base;
	logic        int_hit;
	logic        cs_hit;

	// Every register of this bank answers only in configuration state
	assign in_config = (state_reg == pnp_ldev_pkg::st_config);
	// Writes land only in configuration state; outside it the strobe
	// is dropped before any field decode sees it
	assign cfg_write = data_port_wr_in & in_config; // R2 R20

	// Index decode, shared by the write processes and the state machine;
	// kept in one place so every user decodes the index alike
	function automatic logic is_idx(input logic [7:0] a, input logic [7:0] b);
		is_idx = (a == b);
	endfunction : is_idx

	// Card state; a card-select write after isolation enters config.
	// This is a minimal local copy of the card-level sequence: only
	// the states that gate this bank are kept. Returning to the wait
	// state has priority, so a key-wait request always wins.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= pnp_ldev_pkg::st_wait;
		end else if (wait_for_key_in) begin
			state_reg <= pnp_ldev_pkg::st_wait;
		end else begin
			case (state_reg)
				pnp_ldev_pkg::st_wait: begin
					// Isolation entry is signalled by card-level logic,
					// which runs the serial isolation protocol itself
					if (isolation_won_in) begin
						state_reg <= pnp_ldev_pkg::st_isolation;
					end
				end
				// Card won isolation and waits for its select number
				pnp_ldev_pkg::st_isolation: begin
					// Any value written to the select number is accepted
					if (data_port_wr_in &&
					    is_idx(index_reg, pnp_ldev_pkg::idx_card_select)) begin
						state_reg <= pnp_ldev_pkg::st_config; // R22
					end
				end
				// Left only through key wait or reset
				pnp_ldev_pkg::st_config: begin
					state_reg <= pnp_ldev_pkg::st_config;
				end
				// Unused encoding falls back to the safe idle state
				default: begin
					state_reg <= pnp_ldev_pkg::st_wait;
				end
			endcase
		end
	end

	// Index register written through the address port. The index is
	// taken in every card state, so the host may select a register
	// before the card has been placed in configuration state.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			index_reg <= pnp_ldev_pkg::reset_byte;
		end else if (addr_port_wr_in) begin
			// Any value; unknown indices simply read zero
			index_reg <= host_wdata_in; // R23
		end
	end

	// Activate and range-check controls. Both bits store even while
	// the device is active; the range-check path decides when the
	// enable bit counts, so software may arm it in advance.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			device_active_flag_reg   <= 1'b0;
			check_en_reg             <= 1'b0;
			check_pattern_select_reg <= 1'b0;
		end else if (cfg_write) begin
			// Only the low bits store; reserved bits are dropped
			if (is_idx(index_reg, pnp_ldev_pkg::idx_activate)) begin
				device_active_flag_reg <=
					host_wdata_in[pnp_ldev_pkg::active_bit]; // R3 R21
			end
			// Enable and pattern select share one write
			if (is_idx(index_reg, pnp_ldev_pkg::idx_range_check)) begin
				check_en_reg <= host_wdata_in[pnp_ldev_pkg::check_en_bit];
				check_pattern_select_reg <=
					host_wdata_in[pnp_ldev_pkg::pattern_bit];
			end
		end
	end

	// Internal window base and control; no documented reset, zero chosen
	// so the window stays closed and decodes nothing until software
	// has set the enable bit, whatever base is then stored
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			internal_mem_base_high_reg <= pnp_ldev_pkg::reset_byte;
			internal_mem_base_low_reg  <= 4'h0;
			int_width_reg              <= 1'b0;
			internal_memory_enable_reg <= 1'b0;
		end else if (cfg_write) begin
			// Full byte of base bits 23:16
			if (is_idx(index_reg, pnp_ldev_pkg::idx_int_base_high)) begin
				internal_mem_base_high_reg <= host_wdata_in; // R8
			end
			// Bits 11:8 are not stored, so a stray write is harmless
			if (is_idx(index_reg, pnp_ldev_pkg::idx_int_base_low)) begin
				internal_mem_base_low_reg <= host_wdata_in[7:4]; // R7 R8
			end
			// Width bit only; reserved and compare-select bits never store
			if (is_idx(index_reg, pnp_ldev_pkg::idx_int_control)) begin
				int_width_reg <=
					host_wdata_in[pnp_ldev_pkg::width_bit]; // R9 R10 R11
			end
			// Only bit 12 of the mask stores; the high byte is read-only
			if (is_idx(index_reg, pnp_ldev_pkg::idx_int_mask_low)) begin
				internal_memory_enable_reg <=
					host_wdata_in[pnp_ldev_pkg::mask_enable_bit]; // R12 R21
			end
		end
	end

	// External chip-select window base and control. These reset to
	// zero, so a card activated before software writes a base selects
	// the lowest window of the address space.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			chipsel_base_high_reg <= pnp_ldev_pkg::reset_byte; // R17
			chipsel_base_low_reg  <= pnp_ldev_pkg::reset_byte; // R17
			cs_width_reg          <= 1'b0;
		end else if (cfg_write) begin
			// Base bits 23:16
			if (is_idx(index_reg, pnp_ldev_pkg::idx_cs_base_high)) begin
				chipsel_base_high_reg <= host_wdata_in;
			end
			// Base bits 15:8
			if (is_idx(index_reg, pnp_ldev_pkg::idx_cs_base_low)) begin
				chipsel_base_low_reg <= host_wdata_in;
			end
			// Width bit only; the decode-option bit is fixed
			if (is_idx(index_reg, pnp_ldev_pkg::idx_cs_control)) begin
				cs_width_reg <=
					host_wdata_in[pnp_ldev_pkg::width_bit]; // R18 R19
			end
		end
	end

	// Window description words, in host address bits 23 to 8
	// Base bits 11:8 fixed zero, bits 7:0 implied zero
	assign internal_base = {internal_mem_base_high_reg,
	                        internal_mem_base_low_reg, 4'h0}; // R8
	// Mask is all-ones from bit 12 up when enabled, else zero; whatever
	// software wrote to the other mask bits is never stored
	assign internal_range_mask = internal_memory_enable_reg ?
		{pnp_ldev_pkg::mask_high_on, pnp_ldev_pkg::mask_low_on} :
		16'h0000; // R12 R13 R14
	// Chip-select base, both bytes fully stored
	assign chipsel_window_base = {chipsel_base_high_reg,
	                              chipsel_base_low_reg};

	// Read mux; all unlisted indices in this bank read zero. Indices of
	// registers kept elsewhere on the card also fall in the default,
	// so the card-level read path must take precedence over this one.
	always_comb begin
		// Default first, so every path assigns the byte
		read_value = pnp_ldev_pkg::zero_byte; // R6 R16
		case (index_reg)
			// Reserved bits 7:1 read zero
			pnp_ldev_pkg::idx_activate: begin
				read_value = {7'h00, device_active_flag_reg}; // R3
			end
			// Enable in bit 1, pattern select in bit 0
			pnp_ldev_pkg::idx_range_check: begin
				read_value = {6'h00, check_en_reg, check_pattern_select_reg};
			end
			// Internal base bits 23:16
			pnp_ldev_pkg::idx_int_base_high: begin
				read_value = internal_mem_base_high_reg;
			end
			// Base bits 15:12, bits 11:8 always zero
			pnp_ldev_pkg::idx_int_base_low: begin
				read_value = {internal_mem_base_low_reg, 4'h0};
			end
			pnp_ldev_pkg::idx_int_control: begin
				// Compare-select bit 0 always reads zero
				read_value = {6'h00, int_width_reg, 1'b0}; // R10 R11
			end
			// Copies of the enable bit
			pnp_ldev_pkg::idx_int_mask_high: begin
				read_value = internal_range_mask[15:8]; // R13 R14
			end
			// Enable in bit 4, mask bits 11:8 zero
			pnp_ldev_pkg::idx_int_mask_low: begin
				read_value = internal_range_mask[7:0]; // R12
			end
			// Chip-select base bits 23:16
			pnp_ldev_pkg::idx_cs_base_high: begin
				read_value = chipsel_base_high_reg;
			end
			// Chip-select base bits 15:8
			pnp_ldev_pkg::idx_cs_base_low: begin
				read_value = chipsel_base_low_reg;
			end
			// Width bit, decode option reads zero
			pnp_ldev_pkg::idx_cs_control: begin
				read_value = {6'h00, cs_width_reg, 1'b0}; // R18 R19
			end
			default: begin
				read_value = pnp_ldev_pkg::zero_byte; // R6 R16
			end
		endcase
	end

	// Registered read data; the bus is left undriven outside config.
	// The answer stands for one cycle only; data returns to zero with
	// the drive so a stale byte never lingers on the pins.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			host_rdata_out      <= pnp_ldev_pkg::zero_byte;
			host_rdata_oe_n_out <= 1'b1;
		end else if (data_port_rd_in && in_config) begin
			// Drive for exactly the cycle after the read pulse
			host_rdata_out      <= read_value; // R2
			host_rdata_oe_n_out <= 1'b0;
		end else begin
			host_rdata_out      <= pnp_ldev_pkg::zero_byte;
			host_rdata_oe_n_out <= 1'b1; // R20
		end
	end

	// Internal window comparator; the enable also gates the hit, so a
	// zero mask cannot open the window by matching every address
	pnp_window_match u_int_match (
		.base_in   (internal_base),
		.mask_in   (internal_range_mask),
		.enable_in (internal_memory_enable_reg),
		.addr_in   (mem_addr_in[23:8]),
		.hit_out   (int_hit)
	);

	// Chip-select window; its range register lives elsewhere, so the
	// internal 4k mask is not reused and the full base is compared;
	// a wider window needs that outside range logic to qualify it
	pnp_window_match u_cs_match (
		.base_in   (chipsel_window_base),
		.mask_in   (16'hffff),
		.enable_in (1'b1),
		.addr_in   (mem_addr_in[23:8]),
		.hit_out   (cs_hit)
	);

	// Window decode, gated by the active flag. Registering the selects
	// adds one cycle of latency but keeps the outputs free of glitches
	// while the address settles.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			device_active_out        <= 1'b0;
			internal_mem_hit_out     <= 1'b0;
			external_chip_select_out <= 1'b0;
			internal_wide_out        <= 1'b0;
			chipsel_wide_out         <= 1'b0;
		end else begin
			// Active copy for the card-level bus logic
			device_active_out        <= device_active_flag_reg;
			// Selects need a live cycle, a hit and an active device
			internal_mem_hit_out     <= mem_cycle_in & int_hit &
			                            device_active_flag_reg; // R1 R15
			external_chip_select_out <= mem_cycle_in & cs_hit &
			                            device_active_flag_reg; // R1
			// Width copies follow the control bits one cycle later
			internal_wide_out        <= int_width_reg; // R9
			chipsel_wide_out         <= cs_width_reg; // R18
		end
	end

	// Range-check answers on assigned I/O reads while inactive. The
	// enable bit is ignored while active, so normal I/O reads are never
	// answered with the fixed pattern.
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			io_check_data_out  <= pnp_ldev_pkg::zero_byte;
			io_check_drive_out <= 1'b0;
		end else if (io_range_read_in && check_en_reg &&
		             !device_active_flag_reg) begin // R4
			// Pattern select picks one of the two fixed bytes
			io_check_data_out  <= check_pattern_select_reg ?
				pnp_ldev_pkg::pattern_one :
				pnp_ldev_pkg::pattern_zero; // R5
			// Drive flag tells the bus side the byte is valid
			io_check_drive_out <= 1'b1;
		end else begin
			io_check_data_out  <= pnp_ldev_pkg::zero_byte;
			io_check_drive_out <= 1'b0;
		end
	end
endmodule : pnp_logical_device_config_regs

// ==== rtl/pnp_ldev_pkg.sv ====
// Constants for the logical-device configuration register bank.
// How it works
// R1: Active flag gates all host bus cycles
// R2: Registers reachable only in configuration state
// R3: Activate bits 7 to 1 read zero
// R4: Range check acts only while inactive
// R5: Range check reads return 0x55 or 0xaa
// R6: Indices 0x32 to 0x3f read zero
// R7: Software writes zero to base bits 11:8
// R8: Internal base from 0x40 and upper 0x41
// R9: Data-width bit selects 16 or 8 bits
// R10: Internal control bits 7 to 2 read zero
// R11: Compare-select bit reads zero, mask mode
// R12: Only mask bit 12 writable, copied upward
// R13: Enable set opens window, reads 4k mask
// R14: Enable clear closes window, reads zero
// R15: Address compared only where mask set
// R16: Indices 0x45 to 0x47 read zero
// R17: Chip-select base 0x48/0x49 resets zero
// R18: Chip-select control width bit, rest zero
// R19: Chip-select decode bit reads zero
// R20: Inactive-state reads undriven, writes ignored
// R21: Writes to read-only bits ignored
// R22: Card select write enters configuration state
// R23: Index via address port, value via data port
package pnp_ldev_pkg;
	// Configuration indices
	localparam logic [7:0] idx_card_select   = 8'h06;
	localparam logic [7:0] idx_activate      = 8'h30;
	localparam logic [7:0] idx_range_check   = 8'h31;
	localparam logic [7:0] idx_ld_res_lo     = 8'h32;
	localparam logic [7:0] idx_ld_res_hi     = 8'h3f;
	localparam logic [7:0] idx_int_base_high = 8'h40;
	localparam logic [7:0] idx_int_base_low  = 8'h41;
	localparam logic [7:0] idx_int_control   = 8'h42;
	localparam logic [7:0] idx_int_mask_high = 8'h43;
	localparam logic [7:0] idx_int_mask_low  = 8'h44;
	localparam logic [7:0] idx_filler_lo     = 8'h45;
	localparam logic [7:0] idx_filler_hi     = 8'h47;
	localparam logic [7:0] idx_cs_base_high  = 8'h48;
	localparam logic [7:0] idx_cs_base_low   = 8'h49;
	localparam logic [7:0] idx_cs_control    = 8'h4a;
	// Field positions
	localparam int active_bit      = 0;
	localparam int pattern_bit     = 0;
	localparam int check_en_bit    = 1;
	localparam int width_bit       = 1;
	localparam int mask_enable_bit = 4;
	// Reset values and fixed read values
	localparam logic [7:0] reset_byte     = 8'h00;
	localparam logic [7:0] pattern_one    = 8'h55;
	localparam logic [7:0] pattern_zero   = 8'haa;
	localparam logic [7:0] zero_byte      = 8'h00;
	localparam logic [7:0] base_low_mask  = 8'hf0;
	localparam logic [7:0] mask_low_on    = 8'hf0;
	localparam logic [7:0] mask_high_on   = 8'hff;
	// Card states
	typedef enum logic [1:0] {
		st_wait,
		st_isolation,
		st_config
	} card_state_t;
endpackage : pnp_ldev_pkg

// ==== rtl/pnp_window_match.sv ====
// Masked address comparator for one memory window.
`timescale 1ns/1ps
module pnp_window_match (
	// Window description
	input  wire logic [15:0] base_in,
	input  wire logic [15:0] mask_in,
	input  wire logic        enable_in,
	// Host address bits 23 to 8
	input  wire logic [15:0] addr_in,
	// Match result
	output logic             hit_out
);
	// Per-bit agreement, masked bits always agree
	logic [15:0] agree;
	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_bit
			// Only mask-set bits take part in the compare
			assign agree[i] = ~mask_in[i] | (addr_in[i] == base_in[i]); // R15
		end
	endgenerate
	assign hit_out = enable_in & (&agree);
endmodule : pnp_window_match

// ==== verification/pnp_ldev_chk.sv ====
// Port-level checker for the configuration register bank.
`timescale 1ns/1ps
module pnp_ldev_chk (
	// Clock and reset
	input wire logic       clock_in,
	input wire logic       nrst_in,
	// Host side inputs
	input wire logic       data_port_rd_in,
	input wire logic       mem_cycle_in,
	input wire logic       io_range_read_in,
	// Design outputs
	input wire logic [7:0] host_rdata_out,
	input wire logic       host_rdata_oe_n_out,
	input wire logic       device_active_out,
	input wire logic       internal_mem_hit_out,
	input wire logic       external_chip_select_out,
	input wire logic [7:0] io_check_data_out,
	input wire logic       io_check_drive_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	// Two samples of the active copy hide its register lag
	sequence stay_active;
		device_active_out && $past(device_active_out);
	endsequence
	sequence stay_idle;
		!device_active_out && !$past(device_active_out);
	endsequence
	a_answer_has_cause: assert property (
		!host_rdata_oe_n_out |-> $past(data_port_rd_in))
		else $error("read answer without request");
	a_answer_one_cycle: assert property (
		!data_port_rd_in |=> host_rdata_oe_n_out)
		else $error("read data held too long");
	a_idle_bus_zero: assert property (
		host_rdata_oe_n_out |-> host_rdata_out == 8'h00)
		else $error("read data while not driving");
	a_check_pattern: assert property (
		io_check_drive_out |-> io_check_data_out inside {8'h55, 8'haa})
		else $error("bad check pattern");
	a_check_cause: assert property (
		io_check_drive_out |-> $past(io_range_read_in))
		else $error("check data without read");
	a_quiet_pattern: assert property (
		!io_check_drive_out |-> io_check_data_out == 8'h00)
		else $error("check data not zero");
	a_active_no_check: assert property (
		stay_active |-> !io_check_drive_out)
		else $error("range check while active");
	a_mem_hit_cause: assert property (
		internal_mem_hit_out |-> $past(mem_cycle_in))
		else $error("hit without cycle");
	a_cs_cause: assert property (
		external_chip_select_out |-> $past(mem_cycle_in))
		else $error("select without cycle");
	a_inactive_silent: assert property (
		stay_idle |-> !internal_mem_hit_out && !external_chip_select_out)
		else $error("decode while inactive");
endmodule : pnp_ldev_chk

bind pnp_logical_device_config_regs pnp_ldev_chk u_chk (.clock_in, .nrst_in,
	.data_port_rd_in, .mem_cycle_in, .io_range_read_in, .host_rdata_out,
	.host_rdata_oe_n_out, .device_active_out, .internal_mem_hit_out,
	.external_chip_select_out, .io_check_data_out, .io_check_drive_out);

// ==== verification/pnp_host_model.sv ====
// Host model driving the configuration index and data ports.
`timescale 1ns/1ps
module pnp_host_model (
	// Clock
	input  wire logic       clock_in,
	// Strobes and write data
	output logic            addr_wr_out,
	output logic            data_wr_out,
	output logic            data_rd_out,
	output logic [7:0]      wdata_out,
	// Read answer
	input  wire logic [7:0] rdata_in,
	input  wire logic       oe_n_in
);
	// Quiet bus at time zero
	initial begin
		addr_wr_out = 1'h0;
		data_wr_out = 1'h0;
		data_rd_out = 1'h0;
		wdata_out   = 8'h00;
	end
	// One strobe cycle; data flips after so stale bytes never match
	task strobe(input int kind, input logic [7:0] v);
		@(posedge clock_in);
		#1;
		wdata_out   = v;
		addr_wr_out = (kind == 0);
		data_wr_out = (kind == 1);
		data_rd_out = (kind == 2);
		@(posedge clock_in);
		#1;
		addr_wr_out = 1'h0;
		data_wr_out = 1'h0;
		data_rd_out = 1'h0;
		wdata_out   = ~v;
	endtask : strobe
	// Index then data write
	task wr(input logic [7:0] i, input logic [7:0] v);
		strobe(0, i);
		strobe(1, v);
	endtask : wr
	// Index then read; answer sampled in its only cycle
	task rd(input logic [7:0] i, output logic [7:0] d, output logic o);
		strobe(0, i);
		strobe(2, 8'h00);
		d = rdata_in;
		o = oe_n_in;
	endtask : rd
endmodule : pnp_host_model

// ==== verification/pnp_logical_device_config_regs_tb.sv ====
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
module pnp_logical_device_config_regs_tb;
	logic        clock_in;  // Core clock
	logic        nrst_in;   // Reset, active low
	logic        addr_wr;   // Index strobe
	logic        data_wr;   // Data write strobe
	logic        data_rd;   // Data read strobe
	logic [7:0]  wdata;     // Host write byte
	logic        iso_won;   // Isolation won
	logic        key_wait;  // Back to wait state
	logic        mem_cyc;   // Memory cycle
	logic [23:0] mem_addr;  // Memory address
	logic        io_rd;     // Read in I/O range
	logic [7:0]  rdata;     // Read data
	logic        oe_n;      // Read drive, low active
	logic        active;    // Active copy
	logic        ihit;      // Internal hit
	logic        cs;        // Chip select
	logic        iwide;     // Internal width
	logic        cwide;     // Chip-select width
	logic [7:0]  cdata;     // Check data
	logic        cdrv;      // Check drive
	int          errors;    // Mismatch count
	int          checks;    // Compare count
	logic [7:0]  d;         // Last read byte
	logic        o;         // Last read drive
	// Register reset values are all zero
	logic [7:0]  ridx [0:5] = '{8'h30, 8'h31, 8'h43, 8'h44, 8'h48, 8'h49};
	// Index, write byte, expected read
	logic [23:0] tbl [0:14] = '{24'h30ff01, 24'h31ff03, 24'h40a5a5,
		24'h41c0c0, 24'h42ff02, 24'h44fff0, 24'h4300ff, 24'h481212,
		24'h493434, 24'h4aff02, 24'h32ff00, 24'h3fff00, 24'h45ff00,
		24'h47ff00, 24'h300000};
	pnp_logical_device_config_regs u_dut (.clock_in(clock_in),
		.nrst_in(nrst_in), .addr_port_wr_in(addr_wr),
		.data_port_wr_in(data_wr), .data_port_rd_in(data_rd),
		.host_wdata_in(wdata), .isolation_won_in(iso_won),
		.wait_for_key_in(key_wait), .mem_cycle_in(mem_cyc),
		.mem_addr_in(mem_addr), .io_range_read_in(io_rd),
		.host_rdata_out(rdata), .host_rdata_oe_n_out(oe_n),
		.device_active_out(active), .internal_mem_hit_out(ihit),
		.external_chip_select_out(cs), .internal_wide_out(iwide),
		.chipsel_wide_out(cwide), .io_check_data_out(cdata),
		.io_check_drive_out(cdrv));
	pnp_host_model u_host (.clock_in(clock_in), .addr_wr_out(addr_wr),
		.data_wr_out(data_wr), .data_rd_out(data_rd), .wdata_out(wdata),
		.rdata_in(rdata), .oe_n_in(oe_n));
	// Free-running 250 MHz clock
	initial begin
		clock_in = 1'h0;
		forever #2 clock_in = ~clock_in;
	end
	// Compare and count
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// Wait n edges, then settle
	task tick(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask : tick
	// Range-check read; answer comes one cycle later
	task probe(input logic [7:0] exp);
		io_rd = 1'h1;
		tick(1);
		io_rd = 1'h0;
		chk({7'h00, cdrv}, {7'h00, exp != 8'h00});
		chk(cdata, exp);
	endtask : probe
	// One memory cycle and its decoded selects
	task mem(input logic [23:0] a, input logic ih, input logic c);
		// Let an edge pass so back-to-back cycles never share a step
		tick(1);
		mem_cyc  = 1'h1;
		mem_addr = a;
		tick(1);
		mem_cyc = 1'h0;
		chk({7'h00, ihit}, {7'h00, ih});
		chk({7'h00, cs}, {7'h00, c});
	endtask : mem
	// Verdict and end of run
	task final_report;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	// Hang guard
	initial begin
		#100000;
		errors++;
		final_report();
	end
	// Main sequence
	initial begin
		errors   = 0;
		checks   = 0;
		iso_won  = 1'h0;
		key_wait = 1'h0;
		mem_cyc  = 1'h0;
		mem_addr = 24'h000000;
		io_rd    = 1'h0;
		nrst_in  = 1'h0;
		tick(4);
		nrst_in = 1'h1;
		// Before configuration: no answer, write dropped
		u_host.wr(8'h30, 8'h01);
		u_host.rd(8'h30, d, o);
		chk({7'h00, o}, 8'h01);
		chk({7'h00, active}, 8'h00);
		iso_won = 1'h1;
		tick(1);
		iso_won = 1'h0;
		u_host.wr(pnp_ldev_pkg::idx_card_select, 8'h11);
		foreach (ridx[i]) begin
			u_host.rd(ridx[i], d, o);
			chk(d, 8'h00);
		end
		$display("test reset values done");
		foreach (tbl[i]) begin
			u_host.wr(tbl[i][23:16], tbl[i][15:8]);
			u_host.rd(tbl[i][23:16], d, o);
			chk(d, tbl[i][7:0]);
		end
		chk({6'h00, iwide, cwide}, 8'h03);
		$display("test register map done");
		probe(8'h55);
		u_host.wr(8'h31, 8'h02);
		probe(8'haa);
		u_host.wr(8'h31, 8'h00);
		probe(8'h00);
		u_host.wr(8'h31, 8'h03);
		u_host.wr(8'h30, 8'h01);
		probe(8'h00);
		chk({7'h00, active}, 8'h01);
		$display("test range check done");
		mem(24'ha5cfab, 1'h1, 1'h0);
		mem(24'ha5d0ab, 1'h0, 1'h0);
		mem(24'h1234cd, 1'h0, 1'h1);
		mem(24'h1235cd, 1'h0, 1'h0);
		u_host.wr(8'h44, 8'h00);
		u_host.rd(8'h43, d, o);
		chk(d, 8'h00);
		mem(24'ha5c3ab, 1'h0, 1'h0);
		u_host.wr(8'h30, 8'h00);
		mem(24'h1234cd, 1'h0, 1'h0);
		$display("test decode done");
		key_wait = 1'h1;
		tick(1);
		key_wait = 1'h0;
		u_host.rd(8'h30, d, o);
		chk({7'h00, o}, 8'h01);
		$display("test leave config done");
		final_report();
	end
endmodule : pnp_logical_device_config_regs_tb
